/* File: inc/pm_cfg.svh */
`ifndef PM_CFG_SVH
`define PM_CFG_SVH

// ****************************************
// Timing
// ****************************************
`define CLK_HZ        200000000
`define TENTH_MS      100
`define TENTH_CYC     (`CLK_HZ / 1000 * `TENTH_MS)
`define DECLARE_MS    2500
`define CLEAR_MS      10000
`define DECLARE_TENTH (`DECLARE_MS / `TENTH_MS)
`define CLEAR_TENTH   (`CLEAR_MS / `TENTH_MS)
`define SEC_TENTHS    10
`define QTR_S         900
`define DAY_S         86400
`define UNAV_RUN      10
`define SEV_PCT       30

// ****************************************
// Sizes
// ****************************************
`define NCAUSE        4
`define ALM_DEPTH     8
`define H15_DEPTH     16
`define UAT_DEPTH     6
`define DLY_DEPTH     10
`define NEVT          6

// ****************************************
// Register byte offsets
// ****************************************
`define A_CTRL        8'h00
`define A_STATUS      8'h04
`define A_CLR         8'h08
`define A_SEL         8'h10
`define A_CUR15       8'h14
`define A_CUR24       8'h18
`define A_H15_CNT     8'h1C
`define A_H15_TS      8'h20
`define A_H24_CNT     8'h24
`define A_H24_TS      8'h28
`define A_ALM         8'h2C
`define A_ALM_DAY     8'h30
`define A_UAT_START   8'h34
`define A_UAT_STOP    8'h38
`define A_UAT_DAY     8'h3C
`define A_TIME        8'h40
`define A_TIME_DAY    8'h44

// ****************************************
// Control fields and reset values
// ****************************************
`define CTRL_WRAP     0
`define CTRL_HALT     1
`define CTRL_SKIP0    2
`define CTRL_FLUSH    3
`define CTRL_RST      3'h0

`endif

/* File: inc/pm_pkg.sv */
`include "pm_cfg.svh"

package pm_pkg;

    // ****************************************
    // Carriers
    // ****************************************
    typedef struct packed {
        logic tick;
        logic near_err;
        logic far_err;
    } blk_in_t;

    typedef struct packed {
        logic near;
        logic far;
    } defect_t;

    typedef struct packed {
        logic [15:0] day;
        logic [16:0] sod;
    } stamp_t;

    typedef struct packed {
        stamp_t      ts;
        logic [3:0]  tenth;
        logic [1:0]  cause;
        logic        raised;
    } alm_t;

    typedef struct packed {
        logic [31:0] cnt;
        logic [15:0] day;
        logic [6:0]  qtr;
        logic        susp;
    } hist_t;

    typedef struct packed {
        logic        dir;
        logic        open;
        stamp_t      start;
        stamp_t      stop;
    } uat_t;

    typedef struct packed {
        logic [1:0]       err_sec;
        logic [1:0]       sev_sec;
        logic [1:0][15:0] bg_err;
        logic [1:0]       unav;
        stamp_t           ts;
    } sec_t;

    typedef struct packed {
        logic [24:0]                    cyc;
        logic [3:0]                     tenth;
        logic [16:0]                    sod;
        logic [9:0]                     qsec;
        logic [6:0]                     qtr;
        logic [15:0]                    day;
        logic [2:0]                     ctrl;
        logic [`NCAUSE-1:0][6:0]        ftmr;
        logic [`NCAUSE-1:0]             fail;
        logic [`ALM_DEPTH-1:0]          unused_pad;
        alm_t [`ALM_DEPTH-1:0]          alm;
        logic [2:0]                     awp;
        logic [3:0]                     acnt;
        logic [15:0]                    near_errored_block_count;
        logic [15:0]                    far_errored_block_count;
        logic [15:0]                    blocks;
        logic                           near_defect_second;
        logic                           far_defect_second;
        sec_t [`DLY_DEPTH-1:0]          dl;
        logic [1:0]                     unav;
        logic [1:0][3:0]                run;
        logic [1:0]                     last_out;
        logic [`NEVT-1:0][31:0]         cur15;
        logic [`NEVT-1:0][31:0]         cur24;
        hist_t [`NEVT-1:0][`H15_DEPTH-1:0] h15;
        hist_t [`NEVT-1:0]              h24;
        logic [1:0]                     susp15;
        logic [1:0]                     susp24;
        uat_t [`UAT_DEPTH-1:0]          uat;
        logic [2:0]                     uwp;
        logic [1:0][2:0]                uidx;
        logic [31:0]                    sel;
        logic [31:0]                    prdata;
        logic                           err;
    } state_t;

endpackage : pm_pkg

/* File: src/perf_monitor_event_counters.sv */
// Chosen here: the register addresses and the APB register port.
`timescale 1ns/1ps
`include "pm_cfg.svh"

// Notes on behaviour
// - Failure declared after cause present 2.5 s without break.
// - Failure removed after cause absent 10 s without break.
// - Alarm store keeps full message; readable any time by software.
// - Alarm store full behaviour selectable: wrap over oldest or stop.
// - Flush and halt of alarm store act at once.
// - Near errored second: near defect second or errored blocks >= 1.
// - Near severe second: near defect or errored blocks >= 30 %.
// - Near background errors: block count unless severe second, else 0.
// - Far errored second: no near defect, far defect or blocks >= 1.
// - Far severe second: no near defect, far defect or >= 30 %.
// - Far background errors zero if far severe or near defect.
// - 15-min counters move with day-stamped time to history, clear.
// - Optional skip of moving a zero 15-min counter.
// - Separate 24-h counters move stamped to recent register, clear.
// - Any single current counter clearable alone by command.
// - Suspect flag per stored period, separate near and far.
// - Ten consecutive severe seconds start unavailable time, included.
// - Ten consecutive non-severe seconds restore availability.
// - No counting in unavailable time, with ten second decision delay.
// - Unavailability suppresses counting only for its own direction.
// - Log stamped start and end of at least six unavailable periods.
// - 15-min history is sixteen deep; oldest dropped on push.
// - 24-h history is one register overwritten each day.
module perf_monitor_event_counters #(
    parameter int unsigned TENTH_CYC = `TENTH_CYC
) (
    input  logic                      ref_clk,  // 200 MHz clock
    input  logic                      rst_n,    // Async reset
    input  logic                      psel,     // APB select
    input  logic                      penable,  // APB enable
    input  logic                      pwrite,   // APB write
    input  logic [7:0]                paddr,    // APB byte address
    input  logic [31:0]               pwdata,   // APB write data
    output logic [31:0]               prdata,   // APB read data
    output logic                      pready,   // APB ready
    output logic                      pslverr,  // APB error
    input  logic [`NCAUSE-1:0]        fault,    // Fault causes
    input  pm_pkg::defect_t           defect,   // Defect flags
    input  pm_pkg::blk_in_t           blk,      // Block strobe and errors
    output logic [`NCAUSE-1:0]        failure,  // Declared failures
    output logic [1:0]                unavail   // Far, near unavailable
);
    import pm_pkg::*;

    // ****************************************
    // State
    // ****************************************
    state_t              s;
    state_t              next_s;
    logic                tenth_tick;
    logic                sec_tick;
    logic                qtr_end;
    logic                day_end;
    logic                wr;
    logic [5:0]          clr15;
    logic [5:0]          clr24;
    logic [19:0]         ne10;
    logic [19:0]         fe10;
    logic [19:0]         blk3;
    sec_t                nw;
    sec_t                o;
    logic [5:0][31:0]    inc;
    logic [5:0][31:0]    sum15;
    logic [5:0][31:0]    sum24;
    alm_t                rec;
    logic [3:0]          run;
    logic [2:0]          ev;
    logic [2:0]          ai;
    logic [2:0]          ui;

    // Handshake is combinational; read data is captured in setup
    assign pready  = 1'b1;
    assign prdata  = s.prdata;
    assign pslverr = s.err;
    assign failure = s.fail;
    assign unavail = s.unav;

    // ****************************************
    // Next state
    // ****************************************
    always_comb begin
        next_s = s;
        wr     = psel && penable && pwrite;
        clr15  = (wr && paddr == `A_CLR) ? pwdata[5:0] : 6'h00;
        clr24  = (wr && paddr == `A_CLR) ? pwdata[13:8] : 6'h00;

        // Time base: tenths, seconds, quarters, days
        tenth_tick = s.cyc == 25'(TENTH_CYC - 1);
        sec_tick   = tenth_tick && s.tenth == 4'(`SEC_TENTHS - 1);
        qtr_end    = sec_tick && s.qsec == 10'(`QTR_S - 1);
        day_end    = sec_tick && s.sod == 17'(`DAY_S - 1);
        next_s.cyc = tenth_tick ? 25'h000_0000 : s.cyc + 25'h000_0001;
        if (tenth_tick) begin
            next_s.tenth = sec_tick ? 4'h0 : s.tenth + 4'h1;
        end
        if (sec_tick) begin
            next_s.qsec = qtr_end ? 10'h000 : s.qsec + 10'h001;
            next_s.sod  = day_end ? 17'h0_0000 : s.sod + 17'h0_0001;
            next_s.qtr  = day_end ? 7'h00 : s.qtr + 7'(qtr_end);
            next_s.day  = s.day + 16'(day_end);
        end

        // Persistence filter and alarm recording, tenth-second grain
        rec = '0;
        for (int i = 0; i < `NCAUSE; i++) begin
            if (fault[i] == s.fail[i]) begin
                next_s.ftmr[i] = 7'h00;
            end else if (tenth_tick) begin
                next_s.ftmr[i] = s.ftmr[i] + 7'h01;
                if ((!s.fail[i] &&
                     s.ftmr[i] == 7'(`DECLARE_TENTH - 1)) ||
                    (s.fail[i] &&
                     s.ftmr[i] == 7'(`CLEAR_TENTH - 1))) begin
                    next_s.fail[i] = fault[i];
                    next_s.ftmr[i] = 7'h00;
                    rec = '{ts: '{day: s.day, sod: s.sod}, tenth: s.tenth,
                            cause: 2'(i), raised: fault[i]};
                    // Stop mode drops news once full; wrap overwrites
                    if (!s.ctrl[`CTRL_HALT] &&
                        (s.ctrl[`CTRL_WRAP] ||
                         next_s.acnt != 4'(`ALM_DEPTH))) begin
                        next_s.alm[next_s.awp] = rec;
                        next_s.awp  = next_s.awp + 3'h1;
                        if (next_s.acnt != 4'(`ALM_DEPTH)) begin
                            next_s.acnt = next_s.acnt + 4'h1;
                        end
                    end
                end
            end
        end

        // Interval gathering; the tick closes the second
        next_s.near_errored_block_count = (sec_tick ? 16'h0000 :
            s.near_errored_block_count) + 16'(blk.tick && blk.near_err);
        next_s.far_errored_block_count = (sec_tick ? 16'h0000 :
            s.far_errored_block_count) + 16'(blk.tick && blk.far_err);
        next_s.blocks = (sec_tick ? 16'h0000 : s.blocks) + 16'(blk.tick);
        next_s.near_defect_second = (!sec_tick && s.near_defect_second) ||
                                    defect.near;
        next_s.far_defect_second  = (!sec_tick && s.far_defect_second) ||
                                    defect.far;

        // Per-second classification; 30 % compared as 10*count >= 3*blocks
        ne10 = 20'(s.near_errored_block_count) * 20'h0_000A;
        fe10 = 20'(s.far_errored_block_count) * 20'h0_000A;
        blk3 = 20'(s.blocks) * 20'(`SEV_PCT / 10);
        nw            = '0;
        nw.ts         = '{day: s.day, sod: s.sod};
        nw.unav       = s.unav;
        nw.err_sec[0] = s.near_defect_second ||
                        s.near_errored_block_count != 16'h0000;
        nw.sev_sec[0] = s.near_defect_second ||
                        (s.near_errored_block_count != 16'h0000 &&
                         ne10 >= blk3);
        nw.bg_err[0]  = nw.sev_sec[0] ? 16'h0000 :
                        s.near_errored_block_count;
        nw.err_sec[1] = !s.near_defect_second &&
                        (s.far_defect_second ||
                         s.far_errored_block_count != 16'h0000);
        nw.sev_sec[1] = !s.near_defect_second &&
                        (s.far_defect_second ||
                         (s.far_errored_block_count != 16'h0000 &&
                          fe10 >= blk3));
        nw.bg_err[1]  = (nw.sev_sec[1] || s.near_defect_second) ? 16'h0000 :
                        s.far_errored_block_count;

        // Delay line: the oldest second leaves as the newest enters
        o = s.dl[`DLY_DEPTH-1];
        if (sec_tick) begin
            next_s.dl[0] = nw;
            for (int j = 1; j < `DLY_DEPTH; j++) begin
                next_s.dl[j] = s.dl[j-1];
            end
        end

        // Availability per direction; a flip relabels the ten seconds
        run = 4'h0;
        for (int d = 0; d < 2; d++) begin
            if (sec_tick) begin
                if (nw.sev_sec[d] != s.unav[d]) begin
                    run = s.run[d] + 4'h1;
                    next_s.run[d] = run;
                    if (run == 4'(`UNAV_RUN)) begin
                        next_s.unav[d] = nw.sev_sec[d];
                        next_s.run[d]  = 4'h0;
                        for (int j = 0; j < `DLY_DEPTH; j++) begin
                            next_s.dl[j].unav[d] = nw.sev_sec[d];
                        end
                    end
                end else begin
                    next_s.run[d] = 4'h0;
                end
                // Log edges of unavailability as seconds leave the line
                if (o.unav[d] != s.last_out[d]) begin
                    next_s.last_out[d] = o.unav[d];
                    if (o.unav[d]) begin
                        next_s.uat[next_s.uwp] = '{dir: 1'(d), open: 1'b1,
                                                   start: o.ts, stop: '0};
                        next_s.uidx[d] = next_s.uwp;
                        next_s.uwp = (next_s.uwp == 3'(`UAT_DEPTH - 1)) ?
                                     3'h0 : next_s.uwp + 3'h1;
                    end else begin
                        next_s.uat[s.uidx[d]].stop = o.ts;
                        next_s.uat[s.uidx[d]].open = 1'b0;
                    end
                end
            end
        end

        // Counting of settled seconds, each direction on its own
        for (int d = 0; d < 2; d++) begin
            if (sec_tick && !o.unav[d]) begin
                inc[d*3]   = 32'(o.err_sec[d]);
                inc[d*3+1] = 32'(o.sev_sec[d]);
                inc[d*3+2] = 32'(o.bg_err[d]);
            end else begin
                inc[d*3]   = 32'h0000_0000;
                inc[d*3+1] = 32'h0000_0000;
                inc[d*3+2] = 32'h0000_0000;
            end
        end

        // Current counters and their history
        for (int e = 0; e < `NEVT; e++) begin
            sum15[e] = s.cur15[e] + inc[e];
            sum24[e] = s.cur24[e] + inc[e];
            next_s.cur15[e] = sum15[e];
            next_s.cur24[e] = sum24[e];
            if (qtr_end) begin
                next_s.cur15[e] = 32'h0000_0000;
                if (!(s.ctrl[`CTRL_SKIP0] &&
                      sum15[e] == 32'h0000_0000)) begin
                    for (int j = 1; j < `H15_DEPTH; j++) begin
                        next_s.h15[e][j] = s.h15[e][j-1];
                    end
                    next_s.h15[e][0] = '{cnt: sum15[e], day: s.day,
                                         qtr: s.qtr,
                                         susp: s.susp15[e/3]};
                end
            end
            if (day_end) begin
                next_s.cur24[e] = 32'h0000_0000;
                next_s.h24[e] = '{cnt: sum24[e], day: s.day, qtr: 7'h00,
                                  susp: s.susp24[e/3]};
            end
            // A lone clear wins over counting, marks the period suspect
            if (clr15[e]) begin
                next_s.cur15[e] = 32'h0000_0000;
            end
            if (clr24[e]) begin
                next_s.cur24[e] = 32'h0000_0000;
            end
        end

        // Suspect flags restart each period, raised per direction
        for (int d = 0; d < 2; d++) begin
            if (qtr_end) begin
                next_s.susp15[d] = 1'b0;
            end
            if (day_end) begin
                next_s.susp24[d] = 1'b0;
            end
            if (clr15[d*3 +: 3] != 3'h0) begin
                next_s.susp15[d] = 1'b1;
            end
            if (clr24[d*3 +: 3] != 3'h0) begin
                next_s.susp24[d] = 1'b1;
            end
        end

        // Register writes; flush and halt take effect this edge
        if (wr && paddr == `A_CTRL) begin
            next_s.ctrl = pwdata[2:0];
            if (pwdata[`CTRL_FLUSH]) begin
                next_s.awp  = 3'h0;
                next_s.acnt = 4'h0;
            end
        end
        if (wr && paddr == `A_SEL) begin
            next_s.sel = pwdata;
        end

        // Read data captured in the setup cycle
        ev = s.sel[10:8];
        ai = 3'(s.awp - s.acnt[2:0] + s.sel[18:16]);
        ui = (s.sel[26:24] < 3'(`UAT_DEPTH)) ? s.sel[26:24] : 3'h0;
        if (ev >= 3'(`NEVT)) begin
            ev = 3'h0;
        end
        if (psel && !penable) begin
            next_s.err    = 1'b0;
            next_s.prdata = 32'h0000_0000;
            case (paddr)
                `A_CTRL:      next_s.prdata = 32'(s.ctrl);
                `A_STATUS:    next_s.prdata = {11'h000, s.acnt, 7'h00,
                                               s.unav, 4'h0, s.fail};
                `A_CLR:       next_s.prdata = 32'h0000_0000;
                `A_SEL:       next_s.prdata = s.sel;
                `A_CUR15:     next_s.prdata = s.cur15[ev];
                `A_CUR24:     next_s.prdata = s.cur24[ev];
                `A_H15_CNT:   next_s.prdata = s.h15[ev][s.sel[3:0]].cnt;
                `A_H15_TS:    next_s.prdata = {s.h15[ev][s.sel[3:0]].susp,
                                   8'h00, s.h15[ev][s.sel[3:0]].qtr,
                                   s.h15[ev][s.sel[3:0]].day};
                `A_H24_CNT:   next_s.prdata = s.h24[ev].cnt;
                `A_H24_TS:    next_s.prdata = {s.h24[ev].susp, 15'h0000,
                                               s.h24[ev].day};
                `A_ALM:       next_s.prdata = {8'h00, s.alm[ai].cause,
                                   s.alm[ai].raised, s.alm[ai].tenth,
                                   s.alm[ai].ts.sod};
                `A_ALM_DAY:   next_s.prdata = {16'h0000, s.alm[ai].ts.day};
                `A_UAT_START: next_s.prdata = {s.uat[ui].dir, s.uat[ui].open,
                                   13'h0000, s.uat[ui].start.sod};
                `A_UAT_STOP:  next_s.prdata = {15'h0000, s.uat[ui].stop.sod};
                `A_UAT_DAY:   next_s.prdata = {s.uat[ui].stop.day,
                                               s.uat[ui].start.day};
                `A_TIME:      next_s.prdata = {11'h000, s.tenth, s.sod};
                `A_TIME_DAY:  next_s.prdata = {9'h000, s.qtr, s.day};
                default:      next_s.err    = 1'b1;
            endcase
        end
    end

    // ****************************************
    // Registers
    // ****************************************
    // First periods after reset are partial, so they start suspect
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            s        <= '0;
            s.ctrl   <= `CTRL_RST;
            s.susp15 <= 2'h3;
            s.susp24 <= 2'h3;
        end else begin
            s <= next_s;
        end
    end

endmodule : perf_monitor_event_counters

/* File: verif/pm_checks_properties.sv */
`timescale 1ns/1ps
`include "pm_cfg.svh"
// ****************************************
// Port checks
// ****************************************
module pm_checks #(
    parameter int unsigned TENTH_CYC = 4
) (
    input logic               ref_clk, // Clock
    input logic               rst_n,   // Async reset
    input logic               psel,    // APB select
    input logic               penable, // APB enable
    input logic [7:0]         paddr,   // APB address
    input logic               pready,  // APB ready
    input logic               pslverr, // APB error
    input logic [`NCAUSE-1:0] fault,   // Fault causes
    input pm_pkg::defect_t    defect,  // Defect flags
    input pm_pkg::blk_in_t    blk,     // Block strobe
    input logic [`NCAUSE-1:0] failure, // Failures
    input logic [1:0]         unavail  // Unavailable
);
    import pm_pkg::*;
    logic [15:0] hi_run;
    logic [15:0] lo_run;
    logic [15:0] nd_age;
    // Run lengths of cause 0 and age of the last near error; saturate so long runs never wrap
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            hi_run <= 16'h0000;
            lo_run <= 16'h0000;
            nd_age <= 16'hFFFF;
        end else begin
            hi_run <= fault[0] ? hi_run + 16'(hi_run != 16'hFFFF) : 16'h0000;
            lo_run <= fault[0] ? 16'h0000 : lo_run + 16'(lo_run != 16'hFFFF);
            nd_age <= (defect.near || (blk.tick && blk.near_err)) ? 16'h0000
                      : nd_age + 16'(nd_age != 16'hFFFF);
        end
    end
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    property p_ready; psel |-> pready; endproperty
    a_ready: assert property (p_ready) else $error("pready low");
    property p_unmap; psel && penable && paddr == 8'h0C |-> pslverr;
    endproperty
    a_unmap: assert property (p_unmap) else $error("no error on hole");
    property p_map; psel && penable && paddr == `A_CTRL |-> !pslverr;
    endproperty
    a_map: assert property (p_map) else $error("error on CTRL");
    property p_decl_min; $rose(failure[0]) |-> hi_run >= 20 * TENTH_CYC;
    endproperty
    a_decl_min: assert property (p_decl_min)
        else $error("early declare");
    property p_decl_max; hi_run == 30 * TENTH_CYC |-> failure[0]; endproperty
    a_decl_max: assert property (p_decl_max)
        else $error("late declare");
    property p_clr_min; $fell(failure[0]) |-> lo_run >= 95 * TENTH_CYC;
    endproperty
    a_clr_min: assert property (p_clr_min)
        else $error("early clear");
    property p_clr_max; lo_run == 105 * TENTH_CYC |-> !failure[0]; endproperty
    a_clr_max: assert property (p_clr_max)
        else $error("late clear");
    property p_unav; $rose(unavail[0]) |-> nd_age < 200 * TENTH_CYC;
    endproperty
    a_unav: assert property (p_unav)
        else $error("unavail no cause");
endmodule : pm_checks

bind perf_monitor_event_counters pm_checks #(.TENTH_CYC(TENTH_CYC)) u_chk (
    .ref_clk(ref_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .paddr(paddr), .pready(pready), .pslverr(pslverr), .fault(fault),
    .defect(defect), .blk(blk), .failure(failure), .unavail(unavail));

/* File: verif/perf_monitor_event_counters_tb.sv */
`timescale 1ns/1ps
`include "pm_cfg.svh"
// ****************************************
// Bench
// ****************************************
module perf_monitor_event_counters_tb;
    import pm_pkg::*;
    localparam int unsigned T   = 4;      // Short tenth keeps run brief
    localparam int unsigned SEC = 10 * T;
    logic        ref_clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0;
    logic        pwrite = 1'b0, pready, pslverr, err;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
    logic [3:0]  fault = 4'h0, failure;
    logic [1:0]  unavail;
    defect_t     defect = '0;
    blk_in_t     blk = '0;
    int          fail_count = 0, tests_run = 0, cyc = 0;
    // Rows: near errors, far errors, defects, six expected counts
    logic [33:0] rows [5] = '{{4'h1, 4'h0, 2'b00, 24'h00_0101},
        {4'h3, 4'h0, 2'b00, 24'h00_0011}, {4'h0, 4'h2, 2'b10, 24'h00_0011},
        {4'h0, 4'h2, 2'b01, 24'h01_1000}, {4'h0, 4'h2, 2'b00, 24'h20_1000}};
    perf_monitor_event_counters #(.TENTH_CYC(T)) dut (.ref_clk(ref_clk),
        .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .fault(fault), .defect(defect), .blk(blk),
        .failure(failure), .unavail(unavail));
    // Clock and hang guard
    always #2.5 ref_clk = ~ref_clk;
    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        if (cyc == 12000) begin
            fail_count++;
            tally_and_finish();
        end
    end
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
        @(posedge ref_clk);
        penable <= 1'b1;
        do @(posedge ref_clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        {psel, penable} <= 2'b00;
    endtask : apb
    task chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
            fail_count++;
        end
    endtask : chk
    // Wait until the second-of-day field moves on
    task sync_sec;
        logic [31:0] s0;
        apb(1'b0, `A_TIME, 32'h0000_0000);
        s0 = rd;
        do apb(1'b0, `A_TIME, 32'h0000_0000); while (rd[16:0] === s0[16:0]);
    endtask : sync_sec
    task send_sec(input logic [3:0] ne, fe, input logic [1:0] df);
        int i;
        sync_sec();
        defect <= df;
        for (i = 0; i < 10; i++) begin
            @(posedge ref_clk);
            blk <= {1'b1, i < ne, i < fe};
            @(posedge ref_clk);
            blk <= '0;
        end
        defect <= '0;
    endtask : send_sec
    task rd_cur(input logic [7:0] a, input int e);
        apb(1'b1, `A_SEL, 32'(e) << 8);
        apb(1'b0, a, 32'h0000_0000);
    endtask : rd_cur
    task tally_and_finish;
        $display("Checks %0d, mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : tally_and_finish
    // Main sequence: table rows, then hand-written cases
    initial begin
        int r, e;
        repeat (8) @(posedge ref_clk);
        rst_n <= 1'b1;
        apb(1'b0, `A_CTRL, 32'h0000_0000);
        chk(rd, {29'h0, `CTRL_RST});
        apb(1'b0, 8'h0C, 32'h0000_0000);
        chk({err, rd[30:0]}, 32'h8000_0000);
        for (r = 0; r < 5; r++) begin
            apb(1'b1, `A_CLR, 32'h0000_3F3F);
            send_sec(rows[r][33:30], rows[r][29:26], rows[r][25:24]);
            repeat (11 * SEC) @(posedge ref_clk);
            for (e = 0; e < 3; e++) begin
                rd_cur(`A_CUR15, e);
                chk(rd, 32'(rows[r][4*e+:4]));
            end
            for (e = 3; e < 6; e++) begin
                rd_cur(`A_CUR15, e);
                chk(rd, 32'(rows[r][4*e+:4]));
            end
        end
        // Clear one counter only; its neighbours keep their counts
        apb(1'b1, `A_CLR, 32'h0000_0020);
        rd_cur(`A_CUR15, 5);
        chk(rd, 32'h0000_0000);
        rd_cur(`A_CUR15, 3);
        chk(rd, 32'h0000_0001);
        rd_cur(`A_CUR24, 5);
        chk(rd, 32'h0000_0002);
        // Long near defect: near unavailable, far untouched, no counting
        apb(1'b1, `A_CLR, 32'h0000_3F3F);
        defect <= 2'b10;
        repeat (12 * SEC) @(posedge ref_clk);
        chk({30'h0, unavail}, 32'h0000_0001);
        defect <= 2'b00;
        repeat (12 * SEC) @(posedge ref_clk);
        chk({30'h0, unavail}, 32'h0000_0000);
        repeat (11 * SEC) @(posedge ref_clk);
        rd_cur(`A_CUR15, 1);
        chk(rd, 32'h0000_0000);
        // Short cause 1 is filtered, cause 0 declared then cleared
        fault <= 4'h3;
        repeat (10 * T) @(posedge ref_clk);
        fault <= 4'h1;
        repeat (25 * T) @(posedge ref_clk);
        chk({28'h0, failure}, 32'h0000_0001);
        fault <= 4'h0;
        repeat (110 * T) @(posedge ref_clk);
        chk({28'h0, failure}, 32'h0000_0000);
        // Alarm count sits at bits 20:17 of the status word
        apb(1'b0, `A_STATUS, 32'h0000_0000);
        chk({28'h0, rd[20:17]}, 32'h0000_0002);
        apb(1'b1, `A_CTRL, 32'h0000_0008);
        apb(1'b0, `A_STATUS, 32'h0000_0000);
        chk({28'h0, rd[20:17]}, 32'h0000_0000);
        tally_and_finish();
    end
endmodule : perf_monitor_event_counters_tb
